// file: hw/scp_params.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH

`define SCP_OFF_CTRL      4'h0
`define SCP_OFF_TRIM      4'h4
`define SCP_OFF_STAT      4'h8
`define SCP_OFF_FUSE      4'hc

`define SCP_CTRL_CE_BIT   7
`define SCP_STAT_PEND_BIT 4
`define SCP_STAT_OPEN_BIT 5
`define SCP_STAT_RSV_BIT  6
`define SCP_STAT_TMO_BIT  7

`define SCP_CODE_PLAIN    4'h0
`define SCP_CODE_FUSED    4'h3
`define SCP_CODE_MAX      4'h8

`define SCP_CE_WINDOW     3'h4

`define SCP_RESP_OKAY     2'h0
`define SCP_RESP_SLVERR   2'h2

`endif

// file: hw/scp_pkg.sv
// Types shared by the system clock prescaler and trim block
package scp_pkg;

  typedef logic [3:0] scp_code_t;

  typedef struct packed {
    logic [31:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        rready;
  } scp_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } scp_axi_rsp_t;

  typedef enum logic [1:0] {
    SCP_SEQ_IDLE = 2'b01,
    SCP_SEQ_OPEN = 2'b10
  } scp_seq_t;

endpackage : scp_pkg

// file: hw/scp_axil.sv
// AXI4-Lite slave front end with 8-bit registers in byte lane 0
`include "scp_params.svh"
module scp_axil #(
  parameter int ADDR_W = 4
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire scp_pkg::scp_axi_req_t req,
  output scp_pkg::scp_axi_rsp_t     rsp,
  output wire logic                 wr_en,
  output wire logic [ADDR_W-1:0]    wr_addr,
  output wire logic [7:0]           wr_data,
  output wire logic                 wr_lane0,
  input  wire logic                 wr_err,
  output wire logic [ADDR_W-1:0]    rd_addr,
  input  wire logic [7:0]           rd_data,
  input  wire logic                 rd_err
);
  import scp_pkg::*;

  logic              aw_got;
  logic              w_got;
  logic              ar_got;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [ADDR_W-1:0] ar_addr_q;
  logic [7:0]        w_data_q;
  logic              w_lane_q;

  assign wr_en    = aw_got & w_got & ~rsp.bvalid;
  assign wr_addr  = aw_addr_q;
  assign wr_data  = w_data_q;
  assign wr_lane0 = w_lane_q;
  assign rd_addr  = ar_addr_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      rsp         <= '0;
      rsp.awready <= 1'b1;
      rsp.wready  <= 1'b1;
      rsp.arready <= 1'b1;
      aw_got      <= 1'b0;
      w_got       <= 1'b0;
      ar_got      <= 1'b0;
      aw_addr_q   <= '0;
      ar_addr_q   <= '0;
      w_data_q    <= 8'h00;
      w_lane_q    <= 1'b0;
    end else begin
      if (req.awvalid && rsp.awready) begin
        rsp.awready <= 1'b0;
        aw_got      <= 1'b1;
        aw_addr_q   <= req.awaddr[ADDR_W-1:0];
      end
      if (req.wvalid && rsp.wready) begin
        rsp.wready <= 1'b0;
        w_got      <= 1'b1;
        w_data_q   <= req.wdata[7:0];
        w_lane_q   <= req.wstrb[0];
      end
      if (wr_en) begin
        rsp.bvalid <= 1'b1;
        rsp.bresp  <= wr_err ? `SCP_RESP_SLVERR : `SCP_RESP_OKAY;
      end
      if (rsp.bvalid && req.bready) begin
        rsp.bvalid  <= 1'b0;
        aw_got      <= 1'b0;
        w_got       <= 1'b0;
        rsp.awready <= 1'b1;
        rsp.wready  <= 1'b1;
      end
      if (req.arvalid && rsp.arready) begin
        rsp.arready <= 1'b0;
        ar_got      <= 1'b1;
        ar_addr_q   <= req.araddr[ADDR_W-1:0];
      end
      if (ar_got && !rsp.rvalid) begin
        rsp.rvalid <= 1'b1;
        rsp.rdata  <= {24'h000000, rd_data};
        rsp.rresp  <= rd_err ? `SCP_RESP_SLVERR : `SCP_RESP_OKAY;
      end
      if (rsp.rvalid && req.rready) begin
        rsp.rvalid  <= 1'b0;
        ar_got      <= 1'b0;
        rsp.arready <= 1'b1;
      end
    end
  end

endmodule // scp_axil

// file: hw/scp_divider.sv
// Power-of-two divider of the master clock with boundary-only switching
module scp_divider #(
  parameter int CNT_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire scp_pkg::scp_code_t reset_code,
  input  wire scp_pkg::scp_code_t new_code,
  input  wire logic              new_valid,
  output scp_pkg::scp_code_t     active_code,
  output logic                   pending,
  output logic                   tick,
  output logic                   phase
);
  import scp_pkg::*;

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] mask;
  logic [CNT_W-1:0] next_cnt;
  logic             boundary;
  logic             rst_seen;
  scp_code_t        pend_code;

  // Count is free running and never visible to software
  assign mask     = ~({CNT_W{1'b1}} << active_code);
  assign boundary = (cnt & mask) == mask;
  assign next_cnt = boundary ? '0 : cnt + 1'b1;

  // Counter keeps running through reset so the clock stays alive
  // An unknown flag at power-up falls to the clearing branch
  always_ff @(posedge clk) begin
    rst_seen <= rst_seen | rst;
    if (!rst || rst_seen) begin
      cnt   <= next_cnt;
      tick  <= boundary;
      phase <= phase ^ boundary;
    end else begin
      cnt   <= '0;
      tick  <= 1'b0;
      phase <= 1'b0;
    end
  end

  // New factor only at the end of an old period, so no short pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      active_code <= reset_code;
      pend_code   <= reset_code;
      pending     <= 1'b0;
    end else if (new_valid) begin
      pend_code <= new_code;
      pending   <= 1'b1;
    end else if (pending && boundary) begin
      active_code <= pend_code;
      pending     <= 1'b0;
    end
  end

endmodule // scp_divider

// file: hw/scp_top.sv
// System clock prescaler with timed change sequence and oscillator trim
//
// Overview of operation
// - With clock-out fuse set, pin carries the system clock, also in reset.
// - The pin shows the divided clock, whatever the source.
// - CPU, flash, I/O and ADC clock enables all follow one divided tick.
// - A factor change gives no glitch and no faster intermediate clock.
// - New factor starts after the old period ends, then one new period.
// - Divider is a free counter on the master clock, not readable.
// - Change-enable is set only when all other bits are written zero.
// - Change-enable clears after four cycles or on the code write.
// - Rewriting enable during the window neither extends nor clears it, except in the expiry cycle, where it restarts the window.
// - Code n divides by two to the n, up to 8; 9 to 15 reserved.
// - Reset code is 0000, or 0011 when the divide-by-eight fuse is set.
// - Any valid code is accepted at run time whatever the fuse.
// - Trim register loads the factory value at reset, software may rewrite.
// - Top trim bit picks the low or high oscillator range.
// - Lower seven trim bits tune frequency upward within the range.
`include "scp_params.svh"
module scp_top #(
  parameter int ADDR_W = 4,
  parameter int CNT_W  = 8
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire scp_pkg::scp_axi_req_t axi_req,
  output scp_pkg::scp_axi_rsp_t      axi_rsp,
  input  wire logic                  clock_out_fuse,
  input  wire logic                  divide_by_eight_fuse,
  input  wire logic [7:0]            factory_trim,
  input  wire logic                  io_pin_out,
  input  wire logic                  io_pin_oe,
  output logic                       sys_clock_out_pin,
  output logic                       sys_clock_out_oe,
  output logic                       cpu_clk_en,
  output logic                       flash_clk_en,
  output logic                       io_clk_en,
  output logic                       adc_clk_en,
  output logic                       trim_range_bit,
  output logic [6:0]                 trim_fine_value
);
  import scp_pkg::*;

  // Bus side
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0]        wr_data;
  logic              wr_lane0;
  logic              wr_err;
  logic [ADDR_W-1:0] rd_addr;
  logic [7:0]        rd_data;
  logic              rd_err;

  // Address decode
  logic              wr_is_ctrl;
  logic              wr_is_trim;
  logic              wr_is_stat;
  logic              wr_is_fuse;
  logic              rd_is_ctrl;
  logic              rd_is_trim;
  logic              rd_is_stat;
  logic              rd_is_fuse;
  logic              ctrl_we;
  logic              trim_we;
  logic              stat_we;

  // Control write classes
  logic              ce_write;
  logic              code_write;
  logic              code_ok;

  // Sequence state
  scp_seq_t          seq_state;
  scp_seq_t          next_seq_state;
  logic [2:0]        window_cnt;
  logic [2:0]        next_window_cnt;
  logic              window_expire;
  logic              accept_code;
  logic              reject_code;

  // Stored register contents
  scp_code_t         sel_code;
  logic [7:0]        osc_trim_reg;
  logic              rsv_sticky;
  logic              tmo_sticky;
  logic              fuse_clkout_q;
  logic              fuse_div8_q;
  scp_code_t         reset_code;

  // Divider results
  scp_code_t         active_code;
  logic              div_pending;
  logic              div_tick;
  logic              div_phase;

  // Read words
  logic [7:0]        ctrl_word;
  logic [7:0]        stat_word;
  logic [7:0]        fuse_word;
  logic              ce_bit;

  scp_axil #(
    .ADDR_W (ADDR_W)
  ) u_axil (
    .clk      (clk),
    .rst      (rst),
    .req      (axi_req),
    .rsp      (axi_rsp),
    .wr_en    (wr_en),
    .wr_addr  (wr_addr),
    .wr_data  (wr_data),
    .wr_lane0 (wr_lane0),
    .wr_err   (wr_err),
    .rd_addr  (rd_addr),
    .rd_data  (rd_data),
    .rd_err   (rd_err)
  );

  // Reset factor depends on the divide-by-eight fuse
  assign reset_code = divide_by_eight_fuse ? `SCP_CODE_FUSED
                                           : `SCP_CODE_PLAIN;

  scp_divider #(
    .CNT_W (CNT_W)
  ) u_div (
    .clk         (clk),
    .rst         (rst),
    .reset_code  (reset_code),
    .new_code    (wr_data[3:0]),
    .new_valid   (accept_code),
    .active_code (active_code),
    .pending     (div_pending),
    .tick        (div_tick),
    .phase       (div_phase)
  );

  assign wr_is_ctrl = wr_addr == `SCP_OFF_CTRL;
  assign wr_is_trim = wr_addr == `SCP_OFF_TRIM;
  assign wr_is_stat = wr_addr == `SCP_OFF_STAT;
  assign wr_is_fuse = wr_addr == `SCP_OFF_FUSE;
  assign rd_is_ctrl = rd_addr == `SCP_OFF_CTRL;
  assign rd_is_trim = rd_addr == `SCP_OFF_TRIM;
  assign rd_is_stat = rd_addr == `SCP_OFF_STAT;
  assign rd_is_fuse = rd_addr == `SCP_OFF_FUSE;

  // Fuse word is read-only; writes to it are accepted and dropped
  assign wr_err  = ~(wr_is_ctrl | wr_is_trim | wr_is_stat | wr_is_fuse);
  assign rd_err  = ~(rd_is_ctrl | rd_is_trim | rd_is_stat | rd_is_fuse);
  assign ctrl_we = wr_en & wr_lane0 & wr_is_ctrl;
  assign trim_we = wr_en & wr_lane0 & wr_is_trim;
  assign stat_we = wr_en & wr_lane0 & wr_is_stat;

  // Enable is armed only by a word with every other bit zero
  assign ce_write   = ctrl_we & wr_data[`SCP_CTRL_CE_BIT]
                      & (wr_data[6:0] == 7'h00);
  // A code is taken only with the enable bit written zero
  assign code_write = ctrl_we & ~wr_data[`SCP_CTRL_CE_BIT];
  // Codes above 8 are reserved
  assign code_ok    = wr_data[3:0] <= `SCP_CODE_MAX;

  assign ce_bit        = seq_state == SCP_SEQ_OPEN;
  // Window counts system clock cycles, not master cycles
  assign window_expire = ce_bit & div_tick & (window_cnt == 3'h1);
  // Any valid code is accepted, fuse or not
  assign accept_code   = ce_bit & code_write & code_ok;
  assign reject_code   = ce_bit & code_write & ~code_ok;

  always_comb begin
    next_seq_state  = seq_state;
    next_window_cnt = window_cnt;
    case (seq_state)
      SCP_SEQ_IDLE: begin
        if (ce_write) begin
          next_seq_state  = SCP_SEQ_OPEN;
          next_window_cnt = `SCP_CE_WINDOW;
        end
      end
      SCP_SEQ_OPEN: begin
        if (code_write) begin
          next_seq_state  = SCP_SEQ_IDLE;
          next_window_cnt = 3'h0;
        end else if (window_expire && ce_write) begin
          next_window_cnt = `SCP_CE_WINDOW;
        end else if (window_expire) begin
          next_seq_state  = SCP_SEQ_IDLE;
          next_window_cnt = 3'h0;
        end else if (div_tick) begin
          // A rewrite here changes nothing
          next_window_cnt = window_cnt - 3'h1;
        end
      end
      default: begin
        next_seq_state  = SCP_SEQ_IDLE;
        next_window_cnt = 3'h0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      seq_state  <= SCP_SEQ_IDLE;
      window_cnt <= 3'h0;
    end else begin
      seq_state  <= next_seq_state;
      window_cnt <= next_window_cnt;
    end
  end

  // Last accepted code; a reserved code keeps the previous one
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_code <= reset_code;
    end else if (accept_code) begin
      sel_code <= wr_data[3:0];
    end
  end

  // Factory value is taken on a clocked reset edge
  always_ff @(posedge clk) begin
    if (rst) begin
      osc_trim_reg <= factory_trim;
    end else if (trim_we) begin
      osc_trim_reg <= wr_data;
    end
  end

  // Sticky status; a new event in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (rst) begin
      rsv_sticky <= 1'b0;
      tmo_sticky <= 1'b0;
    end else begin
      rsv_sticky <= reject_code
                    | (rsv_sticky
                       & ~(stat_we & wr_data[`SCP_STAT_RSV_BIT]));
      tmo_sticky <= (window_expire & ~code_write & ~ce_write)
                    | (tmo_sticky
                       & ~(stat_we & wr_data[`SCP_STAT_TMO_BIT]));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fuse_clkout_q <= clock_out_fuse;
      fuse_div8_q   <= divide_by_eight_fuse;
    end
  end

  // Control word bits six to four read zero
  assign ctrl_word = {ce_bit, 3'b000, sel_code};
  assign stat_word = {tmo_sticky, rsv_sticky, ce_bit, div_pending,
                      active_code};
  assign fuse_word = {6'h00, fuse_div8_q, fuse_clkout_q};
  assign rd_data   = rd_is_ctrl ? ctrl_word
                   : rd_is_trim ? osc_trim_reg
                   : rd_is_stat ? stat_word
                   : rd_is_fuse ? fuse_word
                   : 8'h00;

  // All synchronous domains share one divided tick
  always_ff @(posedge clk) begin
    cpu_clk_en   <= div_tick;
    flash_clk_en <= div_tick;
    io_clk_en    <= div_tick;
    adc_clk_en   <= div_tick;
  end

  // Fuse overrides the pin's port function, reset or not
  always_ff @(posedge clk) begin
    sys_clock_out_pin <= clock_out_fuse ? div_phase : io_pin_out;
    sys_clock_out_oe  <= clock_out_fuse | io_pin_oe;
  end

  // Range and fine fields go to the oscillator through one register stage
  always_ff @(posedge clk) begin
    trim_range_bit  <= osc_trim_reg[7];
    trim_fine_value <= osc_trim_reg[6:0];
  end

endmodule // scp_top

// file: test/scp_props.sv
// Port-level assertions for the system clock prescaler block
module scp_props #(
  parameter int ADDR_W = 4,
  parameter int CNT_W  = 8
) (
  input logic                  clk,
  input logic                  rst,
  input scp_pkg::scp_axi_req_t axi_req,
  input scp_pkg::scp_axi_rsp_t axi_rsp,
  input logic                  clock_out_fuse,
  input logic                  divide_by_eight_fuse,
  input logic [7:0]            factory_trim,
  input logic                  io_pin_out,
  input logic                  io_pin_oe,
  input logic                  sys_clock_out_pin,
  input logic                  sys_clock_out_oe,
  input logic                  cpu_clk_en,
  input logic                  flash_clk_en,
  input logic                  io_clk_en,
  input logic                  adc_clk_en,
  input logic                  trim_range_bit,
  input logic [6:0]            trim_fine_value
);
  import scp_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Cycles since the previous system tick
  logic [9:0] gap;
  logic       seen;
  always_ff @(posedge clk) begin
    if (rst) begin
      gap  <= 10'h0;
      seen <= 1'b0;
    end else if (cpu_clk_en) begin
      gap  <= 10'h1;
      seen <= 1'b1;
    end else begin
      gap <= gap + 10'h1;
    end
  end

  a_domains_equal: assert property (cpu_clk_en == flash_clk_en &&
    cpu_clk_en == io_clk_en && cpu_clk_en == adc_clk_en)
    else $error("clock domain enables differ");
  a_tick_power_two: assert property (seen && cpu_clk_en |->
    $onehot(gap) && gap <= 10'h100)
    else $error("tick spacing not a power of two");
  a_oe_fuse: assert property (sys_clock_out_oe ==
    $past(clock_out_fuse | io_pin_oe))
    else $error("pin enable wrong");
  a_pin_normal_io: assert property (!$past(clock_out_fuse) |->
    sys_clock_out_pin == $past(io_pin_out))
    else $error("pin does not follow port function");
  a_trim_reset: assert property ($fell(rst) |->
    {trim_range_bit, trim_fine_value} == $past(factory_trim))
    else $error("trim outputs not factory value");
  a_write_answer: assert property (axi_req.awvalid && axi_rsp.awready &&
    axi_req.wvalid && axi_rsp.wready |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid)
    else $error("write response late");
  a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready
    |=> !axi_rsp.rvalid ##1 axi_rsp.rvalid)
    else $error("read response late");
  a_bresp_hold: assert property (axi_rsp.bvalid && !axi_req.bready
    |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (axi_rsp.rvalid && !axi_req.rready
    |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped");
  a_rdata_upper: assert property (axi_rsp.rvalid |->
    axi_rsp.rdata[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule // scp_props

bind scp_top scp_props #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) i_scp_props (
  .clk(clk), .rst(rst), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .clock_out_fuse(clock_out_fuse), .factory_trim(factory_trim),
  .divide_by_eight_fuse(divide_by_eight_fuse), .io_pin_out(io_pin_out),
  .io_pin_oe(io_pin_oe), .sys_clock_out_pin(sys_clock_out_pin),
  .sys_clock_out_oe(sys_clock_out_oe), .cpu_clk_en(cpu_clk_en),
  .flash_clk_en(flash_clk_en), .io_clk_en(io_clk_en),
  .adc_clk_en(adc_clk_en), .trim_range_bit(trim_range_bit),
  .trim_fine_value(trim_fine_value));

// file: test/tb.sv
// Self-checking testbench for the system clock prescaler block
`include "scp_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import scp_pkg::*;
  logic         clk, rst, cof, d8f, iout, ioe, pin, oe, rng;
  logic         c_en, f_en, i_en, a_en;
  logic [6:0]   fine;
  logic [7:0]   ftrim;
  logic [31:0]  rd;
  logic [1:0]   resp;
  scp_axi_req_t req;
  scp_axi_rsp_t rsp;
  int           n_errors, total_checks;

  scp_top i_scp_top (.clk(clk), .rst(rst), .axi_req(req), .axi_rsp(rsp),
    .clock_out_fuse(cof), .divide_by_eight_fuse(d8f), .factory_trim(ftrim),
    .io_pin_out(iout), .io_pin_oe(ioe), .sys_clock_out_pin(pin),
    .sys_clock_out_oe(oe), .cpu_clk_en(c_en), .flash_clk_en(f_en),
    .io_clk_en(i_en), .adc_clk_en(a_en), .trim_range_bit(rng),
    .trim_fine_value(fine));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic print_verdict();
    if (n_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Write one register; bready stays high for the whole run except in t_hold
  task automatic axw(input logic [3:0] a, input logic [7:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    req.awaddr  <= {28'h0, a};
    req.wdata   <= {24'h0, d};
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (rsp.awready === 1'b1) ad = 1'b1;
      if (rsp.wready === 1'b1) wd = 1'b1;
      if (ad) req.awvalid <= 1'b0;
      if (wd) req.wvalid <= 1'b0;
    end
    do @(posedge clk); while (rsp.bvalid !== 1'b1);
    resp = rsp.bresp;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] e,
                     input logic [31:0] m);
    req.araddr  <= {28'h0, a};
    req.arvalid <= 1'b1;
    do @(posedge clk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge clk); while (rsp.rvalid !== 1'b1);
    rd   = rsp.rdata;
    resp = rsp.rresp;
    chk(rd & m, e);
  endtask

  task automatic pulse(input int n);
    repeat (n) do @(posedge clk); while (c_en !== 1'b1);
  endtask

  // Spacing of steady ticks, skipping the switch-over period
  task automatic gap(input int e);
    int n;
    n = 0;
    pulse(2);
    do begin
      @(posedge clk);
      n++;
    end while (c_en !== 1'b1);
    chk(n, e);
  endtask

  task automatic tog(input int e);
    int   n;
    logic p;
    n = 0;
    p = pin;
    do @(posedge clk); while (pin === p);
    p = pin;
    do begin
      @(posedge clk);
      n++;
    end while (pin === p);
    chk(n, e);
  endtask

  task automatic setc(input logic [3:0] c);
    axw(4'h0, 8'h80);
    axw(4'h0, {4'h0, c});
  endtask

  task automatic t_reset();
    rdc(4'h0, 32'h0, '1);
    rdc(4'h4, 32'ha5, '1);
    chk({rng, fine}, 8'ha5);
    rdc(4'h2, 32'h0, '1);
    chk(resp, `SCP_RESP_SLVERR);
  endtask

  task automatic t_codes();
    for (int k = 0; k < 9; k++) begin
      setc(k[3:0]);
      rdc(4'h0, k, '1);
      gap(1 << k);
    end
  endtask

  task automatic t_reserved();
    setc(4'h9);
    rdc(4'h0, 32'h08, '1);
    rdc(4'h8, 32'h48, 32'h4f);
  endtask

  task automatic t_window();
    axw(4'h8, 8'hc0);
    axw(4'h0, 8'h80);
    pulse(1);
    axw(4'h0, 8'h80);
    rdc(4'h0, 32'h88, '1);
    pulse(3);
    repeat (3) @(posedge clk);
    rdc(4'h0, 32'h08, '1);
    rdc(4'h8, 32'h80, 32'h80);
    axw(4'h0, 8'h02);
    rdc(4'h0, 32'h08, '1);
  endtask

  task automatic t_guard();
    setc(4'h3);
    axw(4'h0, 8'h81);
    axw(4'h0, 8'h02);
    rdc(4'h0, 32'h03, '1);
    gap(8);
  endtask

  // Answers must stand while the master is not ready
  task automatic t_hold();
    req.bready <= 1'b0;
    req.rready <= 1'b0;
    axw(4'h4, 8'h3c);
    rdc(4'h4, 32'h3c, '1);
    repeat (3) @(posedge clk);
    chk({rsp.bvalid, rsp.rvalid, rsp.rdata[7:0]}, 10'h33c);
    req.bready <= 1'b1;
    req.rready <= 1'b1;
    @(posedge clk);
  endtask

  task automatic t_trim();
    // No flash write runs in this bench, so any trim is allowed
    axw(4'h4, 8'h7f);
    rdc(4'h4, 32'h7f, '1);
    chk({rng, fine}, 8'h7f);
    axw(4'h4, 8'h80);
    rdc(4'h4, 32'h80, '1);
    chk({rng, fine}, 8'h80);
  endtask

  task automatic t_pin();
    ioe  <= 1'b1;
    iout <= 1'b1;
    repeat (3) @(posedge clk);
    chk({oe, pin}, 2'b11);
    cof <= 1'b1;
    repeat (3) @(posedge clk);
    chk(oe, 1'b1);
    ioe  <= 1'b0;
    iout <= 1'b0;
    tog(8);
  endtask

  task automatic t_fuse_reset();
    int   ch;
    logic p;
    ch = 0;
    d8f <= 1'b1;
    rst <= 1'b1;
    @(posedge clk);
    p = pin;
    repeat (24) begin
      @(posedge clk);
      if (pin !== p) ch++;
      p = pin;
    end
    chk(ch > 0, 1'b1);
    chk(oe, 1'b1);
    rst <= 1'b0;
    @(posedge clk);
    rdc(4'h0, 32'h03, '1);
    rdc(4'hc, 32'h03, '1);
    gap(8);
  endtask

  initial begin
    req         = '0;
    req.wstrb   = 4'hf;
    req.bready  = 1'b1;
    req.rready  = 1'b1;
    {cof, d8f, iout, ioe} = 4'h0;
    ftrim        = 8'ha5;
    rst          = 1'b1;
    n_errors     = 0;
    total_checks = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_codes();
    t_reserved();
    t_window();
    t_guard();
    t_hold();
    t_trim();
    t_pin();
    t_fuse_reset();
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
endmodule // tb
